// ===== design/strap_pkg.sv
// Shared constants and types for the reset, start-up strap and status pin block
package strap_pkg;
   // Bit positions of the start-up option pins in the strap pin vectors
   localparam int PIN_COUNT = 9;
   localparam int PIN_TX = 0;
   localparam int PIN_ERR = 1;
   localparam int PIN_AUDIO = 2;
   localparam int PIN_RATE = 3;
   localparam int PIN_BLOCK = 4;
   localparam int PIN_STATUS = 5;
   localparam int PIN_USER = 6;
   localparam int PIN_GENERAL_OUTPUT_TWO = 7;
   localparam int PIN_SERIAL_DATA_OUTPUT = 8;

   // Pins that stay strap inputs in software mode, and the pins driven after sampling in each mode
   localparam logic [8:0] SW_PIN_MASK = 9'h180;
   localparam logic [8:0] SW_DRIVE_MASK = 9'h181;
   localparam logic [8:0] HW_DRIVE_MASK = 9'h1ff;
   // Reset values: every enable released, every level low
   localparam logic [8:0] OEN_RELEASED = 9'h1ff;
   localparam logic [8:0] PIN_LOW = 9'h000;

   // Block-start timing in frames after the Z preamble
   localparam logic [4:0] BLOCK_LEAD_FRAMES = 5'h02;
   localparam logic [4:0] BLOCK_HIGH_FRAMES = 5'h10;
   localparam logic [4:0] BLOCK_END_FRAMES = 5'h12;

   // Status/user bit buffer depth
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   // Clock rate
   localparam int CLK_PERIOD_NS = 25;

   // Start-up phases
   typedef enum logic [1:0] {ST_SAMPLE, ST_LOW_POWER, ST_SETTLE, ST_ACTIVE} phase_t;
endpackage

// ===== design/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock
   input wire logic clk,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // Elaboration check: a chain of no bits cannot be built
   if (WIDTH < 1) begin : gBadWidth
      $error("pin_sync WIDTH must be at least 1");
   end

   // No reset: the chain must keep tracking the pins while reset is held
   always_ff @(posedge clk) begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
   end

   assign syncOut = sync_reg;
endmodule
`default_nettype wire

// ===== design/reset_startup_strap.sv
// Reset, start-up strap sampling and hardware-mode status pin driver
`timescale 1ns/10ps
`default_nettype none
module reset_startup_strap #(
   parameter logic [3:0] ID_CODE = 4'ha,  // Arbitrary value
   parameter logic [3:0] REV_CODE = 4'h3  // Arbitrary value
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Start-up option pins: level in, level out, enable low while driving
   input wire logic [8:0] strapPinIn,
   output logic [8:0] strapPinOut,
   output logic [8:0] strapPinOeN,
   // Asynchronous pins
   input wire logic [3:0] rxInputs,
   input wire logic [1:0] passthroughInputSelect,
   input wire logic outputWordClock,
   // Receiver events and levels on this clock
   input wire logic zPreamble,
   input wire logic frameStrobe,
   input wire logic rmckRise,
   input wire logic receiverError,
   input wire logic nonValid,
   input wire logic pcmValid,
   input wire logic rateAtMost48,
   input wire logic rateAtLeast881,
   input wire logic pllLocked,
   input wire logic serialDataIn,
   input wire logic gpo2Source,
   input wire logic runBit,
   // Channel status and user bit stream
   input wire logic bitsValid,
   input wire logic statusBitIn,
   input wire logic userBitIn,
   output logic bitsReady,
   // Sampled options and status
   output logic hardwareMode,
   output logic [8:0] strapValues,
   output logic lowPower,
   output logic audioOutEnable,
   output logic [3:0] idCode,
   output logic [3:0] revCode
);
   // Synchronised pins
   logic [8:0] strapSync;
   logic [3:0] rxSync;
   logic [1:0] selSync;
   logic wclkSync;

   pin_sync #(.WIDTH(16)) syncPins (
      .clk(clk),
      .asyncIn({outputWordClock, passthroughInputSelect, rxInputs, strapPinIn}),
      .syncOut({wclkSync, selSync, rxSync, strapSync})
   );

   // Start-up control state
   strap_pkg::phase_t state_reg, state_next;
   logic [8:0] strap_reg, strap_next;
   logic hwMode_reg, hwMode_next;
   logic lowPower_reg, lowPower_next;
   logic audioEn_reg, audioEn_next;
   logic [3:0] id_reg, rev_reg;
   logic running;

   assign running = (state_reg == strap_pkg::ST_SETTLE) || (state_reg == strap_pkg::ST_ACTIVE);

   // Phase sequencing; the sample phase is the first cycle after reset release
   always_comb begin
      state_next = state_reg;
      strap_next = strap_reg;
      hwMode_next = hwMode_reg;
      unique case (state_reg)
         strap_pkg::ST_SAMPLE: begin
            hwMode_next = ~strapSync[strap_pkg::PIN_SERIAL_DATA_OUTPUT];
            if (strapSync[strap_pkg::PIN_SERIAL_DATA_OUTPUT]) begin
               strap_next = strapSync & strap_pkg::SW_PIN_MASK;
               state_next = strap_pkg::ST_LOW_POWER;
            end else begin
               strap_next = strapSync;
               state_next = strap_pkg::ST_SETTLE;
            end
         end
         strap_pkg::ST_LOW_POWER: begin
            if (runBit) begin
               state_next = strap_pkg::ST_SETTLE;
            end
         end
         strap_pkg::ST_SETTLE: begin
            if (!hwMode_reg && !runBit) begin
               state_next = strap_pkg::ST_LOW_POWER;
            end else if (pllLocked) begin
               state_next = strap_pkg::ST_ACTIVE;
            end
         end
         strap_pkg::ST_ACTIVE: begin
            if (!hwMode_reg && !runBit) begin
               state_next = strap_pkg::ST_LOW_POWER;
            end else if (!pllLocked) begin
               state_next = strap_pkg::ST_SETTLE;
            end
         end
      endcase
      lowPower_next = (state_next == strap_pkg::ST_SAMPLE) || (state_next == strap_pkg::ST_LOW_POWER);
      audioEn_next = (state_next == strap_pkg::ST_ACTIVE);
   end

   // Straps change only in the sample phase, so they hold until reset
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= strap_pkg::ST_SAMPLE;
         strap_reg <= strap_pkg::PIN_LOW;
         hwMode_reg <= 1'b0;
         lowPower_reg <= 1'b1;
         audioEn_reg <= 1'b0;
         id_reg <= 4'h0;
         rev_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         strap_reg <= strap_next;
         hwMode_reg <= hwMode_next;
         lowPower_reg <= lowPower_next;
         audioEn_reg <= audioEn_next;
         id_reg <= ID_CODE;
         rev_reg <= REV_CODE;
      end
   end

   // Block-start timing
   logic [4:0] frameCnt_reg, frameCnt_next;
   logic tracking_reg, tracking_next;
   logic blockPin_reg, blockPin_next;
   logic blockTarget;

   assign blockTarget = tracking_reg && (frameCnt_reg >= strap_pkg::BLOCK_LEAD_FRAMES)
                        && (frameCnt_reg < strap_pkg::BLOCK_END_FRAMES);

   // A new Z preamble restarts the count even mid-block
   always_comb begin
      frameCnt_next = frameCnt_reg;
      tracking_next = tracking_reg;
      blockPin_next = blockPin_reg;
      if (!running) begin
         frameCnt_next = 5'h00;
         tracking_next = 1'b0;
      end else if (zPreamble) begin
         frameCnt_next = 5'h00;
         tracking_next = 1'b1;
      end else if (frameStrobe && tracking_reg) begin
         frameCnt_next = frameCnt_reg + 5'h01;
         if (frameCnt_next == strap_pkg::BLOCK_END_FRAMES) begin
            tracking_next = 1'b0;
         end
      end
      if (rmckRise) begin
         blockPin_next = blockTarget;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         frameCnt_reg <= 5'h00;
         tracking_reg <= 1'b0;
         blockPin_reg <= 1'b0;
      end else begin
         frameCnt_reg <= frameCnt_next;
         tracking_reg <= tracking_next;
         blockPin_reg <= blockPin_next;
      end
   end

   // Status/user bit buffer and pin drivers
   logic [1:0] buf_reg [0:1];
   logic [1:0] buf_next [0:1];
   logic [1:0] count_reg, count_next;
   logic ready_reg, ready_next;
   logic wclkPrev_reg;
   logic ratePin_reg, ratePin_next;
   logic [8:0] pinOut_reg, pinOut_next;
   logic [8:0] pinOeN_reg, pinOeN_next;
   logic push, pop, txPick;

   assign txPick = rxSync[selSync];
   assign push = bitsValid && ready_reg;
   assign pop = running && (wclkSync != wclkPrev_reg) && (count_reg != 2'h0);

   // Two-entry FIFO drained one word per word-clock edge; a stall back-pressures the source
   always_comb begin
      logic [1:0] wrIdx;
      wrIdx = 2'h0;
      buf_next[0] = buf_reg[0];
      buf_next[1] = buf_reg[1];
      count_next = count_reg;
      pinOut_next = pinOut_reg;
      pinOeN_next = pinOeN_reg;
      ratePin_next = ratePin_reg;
      if (pop) begin
         buf_next[0] = buf_reg[1];
         pinOut_next[strap_pkg::PIN_STATUS] = buf_reg[0][1];
         pinOut_next[strap_pkg::PIN_USER] = buf_reg[0][0];
      end
      if (!running) begin
         count_next = 2'h0;
      end else begin
         wrIdx = count_reg - {1'b0, pop};
         if (push) begin
            buf_next[wrIdx[0]] = {statusBitIn, userBitIn};
         end
         count_next = count_reg + {1'b0, push} - {1'b0, pop};
      end
      ready_next = running && (count_next < strap_pkg::BUF_DEPTH);
      if (rateAtLeast881) begin
         ratePin_next = 1'b1;
      end else if (rateAtMost48) begin
         ratePin_next = 1'b0;
      end
      if (state_reg == strap_pkg::ST_SAMPLE) begin
         pinOeN_next = ~(hwMode_next ? strap_pkg::HW_DRIVE_MASK : strap_pkg::SW_DRIVE_MASK);
      end
      if (running) begin
         pinOut_next[strap_pkg::PIN_TX] = txPick;
         pinOut_next[strap_pkg::PIN_ERR] = receiverError
                                           || (!strap_reg[strap_pkg::PIN_ERR] && nonValid);
         pinOut_next[strap_pkg::PIN_AUDIO] = ~pcmValid;
         pinOut_next[strap_pkg::PIN_RATE] = ratePin_next;
         pinOut_next[strap_pkg::PIN_BLOCK] = blockPin_next;
         pinOut_next[strap_pkg::PIN_GENERAL_OUTPUT_TWO] = gpo2Source;
         pinOut_next[strap_pkg::PIN_SERIAL_DATA_OUTPUT] = serialDataIn && audioEn_next;
      end else begin
         pinOut_next = strap_pkg::PIN_LOW;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         buf_reg[0] <= 2'h0;
         buf_reg[1] <= 2'h0;
         count_reg <= 2'h0;
         ready_reg <= 1'b0;
         wclkPrev_reg <= 1'b0;
         ratePin_reg <= 1'b0;
         pinOut_reg <= strap_pkg::PIN_LOW;
         pinOeN_reg <= strap_pkg::OEN_RELEASED;
      end else begin
         buf_reg[0] <= buf_next[0];
         buf_reg[1] <= buf_next[1];
         count_reg <= count_next;
         ready_reg <= ready_next;
         wclkPrev_reg <= wclkSync;
         ratePin_reg <= ratePin_next;
         pinOut_reg <= pinOut_next;
         pinOeN_reg <= pinOeN_next;
      end
   end

   // Outputs straight from flops
   assign strapPinOut = pinOut_reg;
   assign strapPinOeN = pinOeN_reg;
   assign bitsReady = ready_reg;
   assign hardwareMode = hwMode_reg;
   assign strapValues = strap_reg;
   assign lowPower = lowPower_reg;
   assign audioOutEnable = audioEn_reg;
   assign idCode = id_reg;
   assign revCode = rev_reg;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_pins_released: assert property (disable iff (1'b0) reset |=> strapPinOeN == strap_pkg::OEN_RELEASED)
      else $error("Strap pins driven during reset");
   // Reset is the antecedent here, so the default disable must not apply
   a_mute_in_reset: assert property (disable iff (1'b0) reset |=> (strapPinOut == strap_pkg::PIN_LOW)
                                     && !audioOutEnable && lowPower)
      else $error("Outputs not muted in reset");
   a_mode_from_strap: assert property ((state_reg == strap_pkg::ST_SAMPLE) |=> hardwareMode == !$past(strapSync[8]))
      else $error("Mode does not follow serial data strap");
   a_sw_two_pins: assert property ((state_reg == strap_pkg::ST_SAMPLE) && strapSync[8] |=> strap_reg[6:0] == 7'h00)
      else $error("Software mode sampled extra straps");
   a_strap_hold: assert property ((state_reg != strap_pkg::ST_SAMPLE) |=> $stable(strap_reg))
      else $error("Strap value changed after sampling");
   a_block_rise: assert property ($rose(blockTarget) |-> frameCnt_reg == 5'h02)
      else $error("Block start did not rise two frames after Z");
   a_block_fall: assert property ($fell(blockTarget) && !$past(zPreamble) && $past(running) |-> frameCnt_reg == 5'h12)
      else $error("Block start not high for sixteen frames");
   a_block_on_recovered_master_clock: assert property (!rmckRise |=> $stable(blockPin_reg))
      else $error("Block start changed without master clock rise");
   a_enable_locked: assert property ($rose(audioOutEnable) |-> $past(pllLocked) && $past(running))
      else $error("Audio outputs enabled before lock");
   a_run_starts: assert property ((state_reg == strap_pkg::ST_LOW_POWER) && runBit |=> !lowPower ##1 running)
      else $error("Run bit did not leave low power");
   a_passthrough: assert property (running && $past(running) |=> strapPinOut[0] == $past(txPick))
      else $error("Passthrough pin does not follow selected input");
   a_buffer_bound: assert property ((count_reg <= 2'h2) && (!bitsReady || count_reg < 2'h2 || pop))
      else $error("Bit buffer overfilled");
endmodule
`default_nettype wire

// ===== dv/strap_host_model.sv
// Board strap resistors and pin levels facing the start-up option pins
`timescale 1ns/10ps
`default_nettype none
module strap_host_model (
   // Strap levels fitted on the board
   input wire logic [8:0] strapLevel,
   // Device side of the option pins
   input wire logic [8:0] strapPinOut,
   input wire logic [8:0] strapPinOeN,
   output logic [8:0] strapPinIn
);
   // Driven pins show the device level, released pins the strap resistor
   // Pin 0 is never strapped: its internal pull-down sets the level
   assign strapPinIn = (strapPinOut & ~strapPinOeN) | (strapLevel & strapPinOeN & 9'h1fe);
endmodule
`default_nettype wire

// ===== dv/reset_startup_strap_tb.sv
// Self-checking bench for the reset, strap sampling and status pin block
`timescale 1ns/10ps
`default_nettype none
module reset_startup_strap_tb;
   localparam int TIME_LIMIT = 3000;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [8:0] strapLevel = 9'h0d4;
   logic [8:0] strapPinIn, strapPinOut, strapPinOeN, strapValues;
   logic [3:0] rxInputs = 4'h0;
   logic [1:0] sel = 2'h0;
   logic wordClk = 1'b0, zPre = 1'b0, frameStb = 1'b0, recovered_master_clock = 1'b1, rxErr = 1'b0, nonValid = 1'b0;
   logic pcmValid = 1'b0, lo48 = 1'b0, hi881 = 1'b0, locked = 1'b0, sdIn = 1'b0, general_output_two = 1'b0;
   logic runBit = 1'b0, bitsValid = 1'b0, stIn = 1'b0, usIn = 1'b0;
   logic bitsReady, hwMode, lowPower, aoe;
   logic [3:0] idCode, revCode, revSeen;
   int numErrors = 0;
   int nCompared = 0;
   int cycles = 0;

   // Device under test and the board around its option pins
   reset_startup_strap #(.ID_CODE(4'h5), .REV_CODE(4'hc)) u_reset_startup_strap (
      .clk(clk), .reset(reset), .strapPinIn(strapPinIn), .strapPinOut(strapPinOut),
      .strapPinOeN(strapPinOeN), .rxInputs(rxInputs), .passthroughInputSelect(sel),
      .outputWordClock(wordClk), .zPreamble(zPre), .frameStrobe(frameStb), .rmckRise(recovered_master_clock),
      .receiverError(rxErr), .nonValid(nonValid), .pcmValid(pcmValid), .rateAtMost48(lo48),
      .rateAtLeast881(hi881), .pllLocked(locked), .serialDataIn(sdIn), .gpo2Source(general_output_two),
      .runBit(runBit), .bitsValid(bitsValid), .statusBitIn(stIn), .userBitIn(usIn),
      .bitsReady(bitsReady), .hardwareMode(hwMode), .strapValues(strapValues), .lowPower(lowPower),
      .audioOutEnable(aoe), .idCode(idCode), .revCode(revCode));
   strap_host_model u_strap_host_model (
      .strapLevel(strapLevel), .strapPinOut(strapPinOut), .strapPinOeN(strapPinOeN),
      .strapPinIn(strapPinIn));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // Cut a hang short; the tests need well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == TIME_LIMIT) begin
         numErrors++;
         wrap_up();
      end
   end

   // Wait n edges, then step off the edge so drives never race sampling
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task chk(input logic [8:0] got, input logic [8:0] exp);
      nCompared++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task endTest(input string name);
      $display("test %s done", name);
   endtask

   // Straps stay fixed through the whole reset so the sampler sees settled levels
   task doReset(input logic [8:0] cfg);
      reset = 1'b1;
      strapLevel = cfg;
      cyc(20);
      reset = 1'b0;
      cyc(4);
   endtask

   // Hold the word until an edge samples ready high; valid is left up for back to back use
   task push(input logic s, input logic u);
      int k;
      k = 0;
      bitsValid = 1'b1;
      stIn = s;
      usIn = u;
      // Ready is registered, so its level now is what the next edge samples
      while (bitsReady !== 1'b1 && k < 50) begin
         k++;
         cyc(1);
      end
      if (k >= 50) begin
         numErrors++;
      end
      cyc(1);
   endtask

   // One word-clock edge, then time for the synchroniser and the output register
   task wordEdge(input logic [1:0] exp);
      wordClk = ~wordClk;
      cyc(6);
      chk({7'h00, strapPinOut[6:5]}, {7'h00, exp});
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial begin
      doReset(9'h0d4);
      chk({8'h00, hwMode}, 9'h001);
      chk(strapValues, 9'h0d4);
      chk(strapPinOeN, 9'h000);
      revSeen = revCode;
      chk({1'b0, idCode, revSeen}, {1'b0, 4'h5, 4'hc});
      strapLevel = 9'h02b;
      cyc(4);
      chk(strapValues, 9'h0d4);
      endTest("hardware straps");

      chk({8'h00, aoe}, 9'h000);
      locked = 1'b1;
      cyc(3);
      chk({8'h00, aoe}, 9'h001);
      for (int i = 0; i < 4; i++) begin
         sel = i[1:0];
         rxInputs = 4'h1 << i;
         cyc(5);
         chk({8'h00, strapPinOut[0]}, 9'h001);
         rxInputs = ~(4'h1 << i);
         cyc(5);
         chk({8'h00, strapPinOut[0]}, 9'h000);
      end
      // Error pin with the strap low reports validity and receiver errors
      nonValid = 1'b1;
      pcmValid = 1'b1;
      hi881 = 1'b1;
      cyc(4);
      chk({6'h00, strapPinOut[3:1]}, 9'h005);
      nonValid = 1'b0;
      rxErr = 1'b1;
      pcmValid = 1'b0;
      hi881 = 1'b0;
      cyc(4);
      chk({6'h00, strapPinOut[3:1]}, 9'h007);
      rxErr = 1'b0;
      lo48 = 1'b1;
      cyc(4);
      chk({6'h00, strapPinOut[3:1]}, 9'h002);
      sdIn = 1'b1;
      locked = 1'b0;
      cyc(4);
      chk({7'h00, aoe, strapPinOut[8]}, 9'h000);
      locked = 1'b1;
      cyc(4);
      chk({7'h00, aoe, strapPinOut[8]}, 9'h003);
      endTest("status pins");

      zPre = 1'b1;
      cyc(1);
      zPre = 1'b0;
      for (int f = 1; f <= 19; f++) begin
         frameStb = 1'b1;
         cyc(1);
         frameStb = 1'b0;
         cyc(4);
         chk({8'h00, strapPinOut[4]}, {8'h00, f >= 2 && f <= 17});
      end
      // With no master clock rise the pin must not follow the new block
      recovered_master_clock = 1'b0;
      zPre = 1'b1;
      cyc(1);
      zPre = 1'b0;
      repeat (2) begin
         frameStb = 1'b1;
         cyc(1);
         frameStb = 1'b0;
         cyc(2);
      end
      cyc(4);
      chk({8'h00, strapPinOut[4]}, 9'h000);
      recovered_master_clock = 1'b1;
      cyc(3);
      chk({8'h00, strapPinOut[4]}, 9'h001);
      endTest("block start");

      push(1'b1, 1'b0);
      push(1'b0, 1'b1);
      bitsValid = 1'b0;
      cyc(2);
      chk({8'h00, bitsReady}, 9'h000);
      wordEdge(2'h1);
      push(1'b1, 1'b1);
      bitsValid = 1'b0;
      wordEdge(2'h2);
      wordEdge(2'h3);
      chk({8'h00, bitsReady}, 9'h001);
      endTest("bit stream");

      reset = 1'b1;
      cyc(2);
      chk(strapPinOeN, 9'h1ff);
      chk(strapPinOut | strapValues, 9'h000);
      chk({1'b0, lowPower, aoe, bitsReady, idCode, 1'b0}, 9'h080);
      endTest("reset mid run");

      doReset(9'h1ff);
      chk({8'h00, hwMode}, 9'h000);
      chk(strapValues, 9'h180);
      chk(strapPinOeN, 9'h07e);
      chk({8'h00, lowPower}, 9'h001);
      strapLevel = 9'h07f;
      cyc(4);
      chk(strapValues, 9'h180);
      runBit = 1'b1;
      cyc(2);
      chk({8'h00, lowPower}, 9'h000);
      general_output_two = 1'b1;
      cyc(4);
      chk({7'h00, aoe, strapPinOut[7]}, 9'h003);
      chk({8'h00, strapPinOut[8]}, 9'h001);
      runBit = 1'b0;
      cyc(3);
      chk({7'h00, lowPower, aoe}, 9'h002);
      endTest("software mode");

      // Error strap high: the pin reports receiver errors only
      doReset(9'h002);
      chk(strapValues, 9'h002);
      nonValid = 1'b1;
      rxErr = 1'b0;
      cyc(4);
      chk({8'h00, strapPinOut[1]}, 9'h000);
      rxErr = 1'b1;
      cyc(4);
      chk({8'h00, strapPinOut[1]}, 9'h001);
      endTest("error strap high");
      wrap_up();
   end
endmodule
`default_nettype wire
